/* File: csl_regs.svh */
// register offsets, bit positions and reset values of the channel status and led block
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
`define CSL_IDX_CHAN_B_STAT 8'h0D
`define CSL_IDX_LED_CTRL 8'h0E
`define CSL_BIT_SOFT_RESET 7
`define CSL_BIT_FRAMER_EN 6
`define CSL_BIT_OC_LAT 5
`define CSL_BIT_UV_LAT 4
`define CSL_BIT_DF_LAT 3
`define CSL_BIT_OC_LIVE 2
`define CSL_BIT_UV_LIVE 1
`define CSL_BIT_DF_LIVE 0
`define CSL_BIT_B_LED2 7
`define CSL_BIT_B_ERR_SEL 6
`define CSL_BIT_B_LED1 5
`define CSL_BIT_B_RDY_SEL 4
`define CSL_BIT_A_LED2 3
`define CSL_BIT_A_ERR_SEL 2
`define CSL_BIT_A_LED1 1
`define CSL_BIT_A_RDY_SEL 0
`define CSL_RST_LED_CTRL 8'h00
`define CSL_RST_CHAN_B 2'h0
`endif

/* File: csl_pkg.sv */
// types of the channel status and led block
package csl_pkg;
    typedef enum logic [2:0] {
        CSL_WR_IDLE = 3'b001,
        CSL_WR_RESP = 3'b010,
        CSL_WR_HOLD = 3'b100
    } csl_wr_state_t;
    typedef struct packed {
        logic soft_reset;
        logic framer_enable;
        logic oc_lat;
        logic uv_lat;
        logic df_lat;
    } csl_chan_b_t;
    typedef struct packed {
        logic prev_oc;
        logic prev_uv;
        logic prev_df;
    } csl_edge_t;
endpackage

/* File: csl_pin_mux.sv */
// one dual-function led / status indicator pin
`timescale 1ns/1ns
module csl_pin_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_select,
    input wire logic led_on,
    input wire logic status_flag,
    output logic pin_out
);
    typedef struct packed {
        logic pin;
    } csl_pin_state_t;
    csl_pin_state_t state_reg;
    csl_pin_state_t state_next;
    always_comb begin
        state_next = state_reg;
        // status flag passes unmasked when selected
        state_next.pin = pin_select ? status_flag : led_on; // (R21)
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign pin_out = state_reg.pin;
endmodule // csl_pin_mux

/* File: csl_status_led.sv */
// channel b status/control and led pin function registers over axi4-lite
//
// Behaviour
// (R1) soft reset clears channel b register bits and both channel b queues
// (R2) soft reset bit clears itself after reset completes, reads zero
// (R3) framer enable turns on internal serial unit, handler and queues
// (R4) software clears framer enable to use an external serial unit
// (R5) latched overcurrent sets on rising live flag, clears on read
// (R6) latched undervoltage sets on rising live flag, clears on read
// (R7) latched driver fault sets on rising live flag, clears on read
// (R8) any latched flag raises the shared status interrupt
// (R9) live overcurrent flag follows the supply current limiter
// (R10) live undervoltage flag follows the power-good detector
// (R11) live driver fault flag follows the line driver fault detector
// (R12) channel b second led bit drives error pin when select is zero
// (R13) channel b error pin shows receive error when select is one
// (R14) channel b error pin ignores the receive error interrupt mask
// (R15) channel b first led bit drives ready pin when select is zero
// (R16) channel b ready pin shows data ready when select is one
// (R17) channel a second led bit drives error pin when select is zero
// (R18) channel a error pin shows receive error when select is one
// (R19) channel a first led bit drives ready pin when select is zero
// (R20) channel a ready pin shows data ready when select is one
// (R21) each pin is a mux of status flag and led bit
// (R22) a set coinciding with a clearing read wins
`timescale 1ns/1ns
`include "csl_regs.svh"
module csl_status_led #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic chan_b_supply_overcurrent_live,
    input wire logic chan_b_supply_undervoltage_live,
    input wire logic chan_b_line_driver_fault_live,
    input wire logic chan_b_receive_error_flag,
    input wire logic chan_b_receive_data_ready_flag,
    input wire logic chan_a_receive_error_flag,
    input wire logic chan_a_receive_data_ready_flag,
    output logic chan_b_frame_handler_enable,
    output logic chan_b_soft_reset,
    output logic shared_status_interrupt,
    output logic chan_a_error_led_pin,
    output logic chan_a_ready_led_pin,
    output logic chan_b_error_led_pin,
    output logic chan_b_ready_led_pin
);
    // ==========================================================
    // state
    typedef struct packed {
        csl_pkg::csl_wr_state_t wr_state;
        logic [ADDR_WIDTH-1:0] aw_addr;
        logic aw_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic w_have;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        csl_pkg::csl_chan_b_t chan_b;
        csl_pkg::csl_edge_t edge_hist;
        logic [7:0] led_ctrl;
    } csl_state_t;
    csl_state_t state_reg;
    csl_state_t state_next;
    localparam logic [ADDR_WIDTH-1:0] ADDR_CHAN_B = ADDR_WIDTH'({`CSL_IDX_CHAN_B_STAT, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] ADDR_LED = ADDR_WIDTH'({`CSL_IDX_LED_CTRL, 2'b00});
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    logic oc_rise;
    logic uv_rise;
    logic df_rise;
    logic rd_fire;
    logic rd_clears;
    logic wr_fire;
    logic [7:0] chan_b_view;
    // ==========================================================
    // live flag edges and register view
    always_comb begin
        // live flags come straight from the analog detectors
        oc_rise = chan_b_supply_overcurrent_live && !state_reg.edge_hist.prev_oc; // (R5)
        uv_rise = chan_b_supply_undervoltage_live && !state_reg.edge_hist.prev_uv; // (R6)
        df_rise = chan_b_line_driver_fault_live && !state_reg.edge_hist.prev_df; // (R7)
        chan_b_view = 8'h00;
        chan_b_view[`CSL_BIT_SOFT_RESET] = state_reg.chan_b.soft_reset;
        chan_b_view[`CSL_BIT_FRAMER_EN] = state_reg.chan_b.framer_enable;
        chan_b_view[`CSL_BIT_OC_LAT] = state_reg.chan_b.oc_lat;
        chan_b_view[`CSL_BIT_UV_LAT] = state_reg.chan_b.uv_lat;
        chan_b_view[`CSL_BIT_DF_LAT] = state_reg.chan_b.df_lat;
        chan_b_view[`CSL_BIT_OC_LIVE] = chan_b_supply_overcurrent_live; // (R9)
        chan_b_view[`CSL_BIT_UV_LIVE] = chan_b_supply_undervoltage_live; // (R10)
        chan_b_view[`CSL_BIT_DF_LIVE] = chan_b_line_driver_fault_live; // (R11)
        rd_fire = s_axi_arvalid && !state_reg.rvalid;
        rd_clears = rd_fire && (s_axi_araddr == ADDR_CHAN_B);
        wr_fire = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
    end
    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.edge_hist.prev_oc = chan_b_supply_overcurrent_live;
        state_next.edge_hist.prev_uv = chan_b_supply_undervoltage_live;
        state_next.edge_hist.prev_df = chan_b_line_driver_fault_live;
        // soft reset done: drop the bit and clear the other channel b bits in the same step
        if (state_reg.chan_b.soft_reset) begin
            state_next.chan_b = '0; // (R1)
            state_next.chan_b.soft_reset = 1'b0; // (R2)
        end
        // clear on read, then set so a coinciding event wins
        if (rd_clears) begin
            state_next.chan_b.oc_lat = 1'b0;
            state_next.chan_b.uv_lat = 1'b0;
            state_next.chan_b.df_lat = 1'b0;
        end
        if (oc_rise) begin
            state_next.chan_b.oc_lat = 1'b1; // (R5) (R22)
        end
        if (uv_rise) begin
            state_next.chan_b.uv_lat = 1'b1; // (R6) (R22)
        end
        if (df_rise) begin
            state_next.chan_b.df_lat = 1'b1; // (R7) (R22)
        end
        // write address and data, either order
        if (s_axi_awvalid && !state_reg.aw_have) begin
            state_next.aw_have = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_have) begin
            state_next.w_have = 1'b1;
            state_next.w_data = s_axi_wdata[7:0];
            state_next.w_lane0 = s_axi_wstrb[0];
        end
        unique case (state_reg.wr_state)
            csl_pkg::CSL_WR_IDLE: begin
                if (wr_fire) begin
                    state_next.aw_have = 1'b0;
                    state_next.w_have = 1'b0;
                    state_next.bvalid = 1'b1;
                    state_next.bresp = RESP_OKAY;
                    state_next.wr_state = csl_pkg::CSL_WR_RESP;
                    if (state_reg.aw_addr == ADDR_CHAN_B) begin
                        if (state_reg.w_lane0) begin
                            // software hands the line to an external unit by clearing this
                            state_next.chan_b.framer_enable =
                                state_reg.w_data[`CSL_BIT_FRAMER_EN]; // (R3) (R4)
                            state_next.chan_b.soft_reset =
                                state_reg.w_data[`CSL_BIT_SOFT_RESET]; // (R1)
                        end
                    end else if (state_reg.aw_addr == ADDR_LED) begin
                        if (state_reg.w_lane0) begin
                            state_next.led_ctrl = state_reg.w_data;
                        end
                    end else begin
                        state_next.bresp = RESP_SLVERR;
                    end
                end
            end
            csl_pkg::CSL_WR_RESP: begin
                if (s_axi_bready) begin
                    state_next.bvalid = 1'b0;
                    state_next.wr_state = csl_pkg::CSL_WR_HOLD;
                end
            end
            csl_pkg::CSL_WR_HOLD: begin
                state_next.wr_state = csl_pkg::CSL_WR_IDLE;
            end
            default: begin
                state_next.wr_state = csl_pkg::CSL_WR_IDLE;
            end
        endcase
        // read channel
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            state_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == ADDR_CHAN_B) begin
                state_next.rdata = {24'h000000, chan_b_view};
            end else if (s_axi_araddr == ADDR_LED) begin
                state_next.rdata = {24'h000000, state_reg.led_ctrl};
            end else begin
                state_next.rresp = RESP_SLVERR;
            end
        end
    end
    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.wr_state <= csl_pkg::CSL_WR_IDLE;
            state_reg.chan_b <= '0;
            state_reg.led_ctrl <= `CSL_RST_LED_CTRL;
        end else begin
            state_reg <= state_next;
        end
    end
    // ==========================================================
    // outputs
    assign s_axi_awready = !state_reg.aw_have;
    assign s_axi_wready = !state_reg.w_have;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign chan_b_frame_handler_enable = state_reg.chan_b.framer_enable; // (R3)
    assign chan_b_soft_reset = state_reg.chan_b.soft_reset; // (R1)
    assign shared_status_interrupt = state_reg.chan_b.oc_lat | state_reg.chan_b.uv_lat
        | state_reg.chan_b.df_lat; // (R8)
    // ==========================================================
    // led / indicator pins
    csl_pin_mux u_b_err (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_select(state_reg.led_ctrl[`CSL_BIT_B_ERR_SEL]),
        .led_on(state_reg.led_ctrl[`CSL_BIT_B_LED2]),
        .status_flag(chan_b_receive_error_flag),
        .pin_out(chan_b_error_led_pin)
    ); // (R12) (R13) (R14)
    csl_pin_mux u_b_rdy (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_select(state_reg.led_ctrl[`CSL_BIT_B_RDY_SEL]),
        .led_on(state_reg.led_ctrl[`CSL_BIT_B_LED1]),
        .status_flag(chan_b_receive_data_ready_flag),
        .pin_out(chan_b_ready_led_pin)
    ); // (R15) (R16)
    csl_pin_mux u_a_err (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_select(state_reg.led_ctrl[`CSL_BIT_A_ERR_SEL]),
        .led_on(state_reg.led_ctrl[`CSL_BIT_A_LED2]),
        .status_flag(chan_a_receive_error_flag),
        .pin_out(chan_a_error_led_pin)
    ); // (R17) (R18)
    csl_pin_mux u_a_rdy (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_select(state_reg.led_ctrl[`CSL_BIT_A_RDY_SEL]),
        .led_on(state_reg.led_ctrl[`CSL_BIT_A_LED1]),
        .status_flag(chan_a_receive_data_ready_flag),
        .pin_out(chan_a_ready_led_pin)
    ); // (R19) (R20)
endmodule // csl_status_led

/* File: csl_status_led_properties.sv */
// checker of the channel status and led block
`timescale 1ns/1ns
module csl_status_led_properties #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic chan_b_supply_overcurrent_live,
    input wire logic chan_b_supply_undervoltage_live,
    input wire logic chan_b_line_driver_fault_live,
    input wire logic chan_b_receive_error_flag,
    input wire logic chan_b_receive_data_ready_flag,
    input wire logic chan_a_receive_error_flag,
    input wire logic chan_a_receive_data_ready_flag,
    input wire logic chan_b_frame_handler_enable,
    input wire logic chan_b_soft_reset,
    input wire logic shared_status_interrupt,
    input wire logic chan_a_error_led_pin,
    input wire logic chan_a_ready_led_pin,
    input wire logic chan_b_error_led_pin,
    input wire logic chan_b_ready_led_pin
);
    // ==========================================
    // write shadow
    localparam logic [ADDR_WIDTH-1:0] ST_ADDR = ADDR_WIDTH'(8'h34);
    localparam logic [ADDR_WIDTH-1:0] LED_ADDR = ADDR_WIDTH'(8'h38);
    logic [ADDR_WIDTH-1:0] wa;
    logic [7:0] wd;
    logic ws;
    logic [7:0] led_sh;
    logic any_live;
    assign any_live = chan_b_supply_overcurrent_live | chan_b_supply_undervoltage_live
        | chan_b_line_driver_fault_live;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa <= '0;
            wd <= 8'h00;
            ws <= 1'h0;
            led_sh <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
            if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
            if ($rose(s_axi_bvalid) && wa == LED_ADDR && ws) led_sh <= wd;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_err_pin: assert property (chan_b_error_led_pin ==
        (led_sh[6] ? $past(chan_b_receive_error_flag) : led_sh[7])) else $error("b error pin");
    a_b_rdy_pin: assert property (chan_b_ready_led_pin ==
        (led_sh[4] ? $past(chan_b_receive_data_ready_flag) : led_sh[5])) else $error("b ready pin");
    a_a_err_pin: assert property (chan_a_error_led_pin ==
        (led_sh[2] ? $past(chan_a_receive_error_flag) : led_sh[3])) else $error("a error pin");
    a_a_rdy_pin: assert property (chan_a_ready_led_pin ==
        (led_sh[0] ? $past(chan_a_receive_data_ready_flag) : led_sh[1])) else $error("a ready pin");
    a_framer_write: assert property ($rose(s_axi_bvalid) && wa == ST_ADDR && ws && !wd[7]
        |-> chan_b_frame_handler_enable == wd[6]) else $error("framer enable");
    a_reset_cause: assert property ($rose(s_axi_bvalid) && wa == ST_ADDR && ws && wd[7]
        |-> ##[0:1] chan_b_soft_reset) else $error("no channel reset");
    a_reset_pulse: assert property (chan_b_soft_reset |=> !chan_b_soft_reset)
        else $error("channel reset stuck");
    a_reset_framer: assert property (chan_b_soft_reset
        |-> ##[0:2] !chan_b_frame_handler_enable) else $error("framer kept through reset");
    a_irq_on_rise: assert property ($rose(any_live)
        |-> ##[1:3] shared_status_interrupt) else $error("interrupt missing");
    a_irq_has_cause: assert property ($rose(shared_status_interrupt)
        |-> $past(any_live) || $past(any_live, 2) || $past(any_live, 3))
        else $error("stray interrupt");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp ==
        (($past(s_axi_araddr) == ST_ADDR || $past(s_axi_araddr) == LED_ADDR) ? 2'h0 : 2'h2))
        else $error("read response");
    c_reset: cover property (chan_b_soft_reset);
    c_irq: cover property ($rose(shared_status_interrupt));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // csl_status_led_properties

bind csl_status_led csl_status_led_properties #(.ADDR_WIDTH(ADDR_WIDTH))
    csl_status_led_properties_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rresp, .s_axi_rvalid, .chan_b_supply_overcurrent_live, .chan_b_supply_undervoltage_live,
    .chan_b_line_driver_fault_live, .chan_b_receive_error_flag, .chan_b_receive_data_ready_flag,
    .chan_a_receive_error_flag, .chan_a_receive_data_ready_flag, .chan_b_frame_handler_enable,
    .chan_b_soft_reset, .shared_status_interrupt, .chan_a_error_led_pin, .chan_a_ready_led_pin,
    .chan_b_error_led_pin, .chan_b_ready_led_pin);

/* File: csl_status_led_tb_top.sv */
// testbench of the channel status and led block
`timescale 1ns/1ns
module csl_status_led_tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, fe, srst, irq;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, pin;
    logic [1:0] bresp, rresp;
    logic [2:0] live = 3'h0;
    logic [3:0] flg = 4'h0;
    int num_errors = 0, n_tests = 0, n_srst = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (srst === 1'h1) n_srst++;
    csl_status_led csl_status_led_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan_b_supply_overcurrent_live(live[2]),
        .chan_b_supply_undervoltage_live(live[1]), .chan_b_line_driver_fault_live(live[0]),
        .chan_b_receive_error_flag(flg[3]), .chan_b_receive_data_ready_flag(flg[2]),
        .chan_a_receive_error_flag(flg[1]), .chan_a_receive_data_ready_flag(flg[0]),
        .chan_b_frame_handler_enable(fe), .chan_b_soft_reset(srst), .shared_status_interrupt(irq),
        .chan_a_error_led_pin(pin[1]), .chan_a_ready_led_pin(pin[0]),
        .chan_b_error_led_pin(pin[3]), .chan_b_ready_led_pin(pin[2]));
    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
        input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= st;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 64);
        bready <= 1'h0;
        chk({29'h0, bvalid, bresp}, {29'h0, 1'h1, er}, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
        input string what);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 64);
        rready <= 1'h0;
        chk({29'h0, rvalid, rresp}, {29'h0, 1'h1, er}, what);
        chk(rdata, {24'h000000, d}, what);
    endtask
    // ==========================================
    // scenarios
    task automatic t_led_pins;
        logic [7:0] pat [5] = '{8'hAA, 8'h55, 8'hFF, 8'h55, 8'h5A};
        logic [3:0] fl [5] = '{4'h0, 4'hA, 4'h0, 4'h5, 4'hF};
        logic [3:0] exp;
        rd(8'h38, 8'h00, 2'h0, "led ctrl reset");
        for (int i = 0; i < 5; i++) begin
            flg <= fl[i];
            wr(8'h38, pat[i], 4'h1, 2'h0);
            cyc(3);
            for (int p = 0; p < 4; p++) exp[p] = pat[i][2*p] ? fl[i][p] : pat[i][2*p+1];
            chk({28'h0, pin}, {28'h0, exp}, "led pins");
            rd(8'h38, pat[i], 2'h0, "led ctrl readback");
        end
        $display("test led pins done");
    endtask
    task automatic t_latched;
        rd(8'h34, 8'h00, 2'h0, "status reset");
        for (int i = 0; i < 3; i++) begin
            live <= 3'h1 << i;
            cyc(4);
            chk({31'h0, irq}, 32'h1, "interrupt raised");
            rd(8'h34, 8'h09 << i, 2'h0, "latched and live");
            cyc(2);
            chk({31'h0, irq}, 32'h0, "interrupt cleared");
            rd(8'h34, 8'h01 << i, 2'h0, "level does not relatch");
            live <= 3'h0;
            cyc(2);
            rd(8'h34, 8'h00, 2'h0, "live cleared");
        end
        fork
            rd(8'h34, 8'h04, 2'h0, "rise during clearing read");
            begin
                @(posedge aclk);
                live <= 3'h4;
            end
        join
        rd(8'h34, 8'h24, 2'h0, "set wins over clear");
        live <= 3'h0;
        cyc(2);
        rd(8'h34, 8'h00, 2'h0, "cleared after rise");
        $display("test latched flags done");
    endtask
    task automatic t_soft_reset;
        wr(8'h34, 8'h40, 4'h1, 2'h0);
        cyc(1);
        chk({31'h0, fe}, 32'h1, "framer on");
        wr(8'h34, 8'h00, 4'h1, 2'h0);
        cyc(1);
        chk({31'h0, fe}, 32'h0, "framer off");
        wr(8'h34, 8'h40, 4'h1, 2'h0);
        wr(8'h38, 8'h0A, 4'h1, 2'h0);
        live <= 3'h2;
        cyc(3);
        wr(8'h34, 8'hC0, 4'h1, 2'h0);
        cyc(3);
        chk(n_srst, 32'h1, "one reset pulse");
        chk({30'h0, fe, irq}, 32'h0, "framer and interrupt cleared");
        rd(8'h34, 8'h02, 2'h0, "status after channel reset");
        rd(8'h38, 8'h0A, 2'h0, "led ctrl untouched");
        live <= 3'h0;
        $display("test soft reset done");
    endtask
    task automatic t_refused;
        wr(8'h3C, 8'hFF, 4'h1, 2'h2);
        rd(8'h3C, 8'h00, 2'h2, "unmapped read");
        wr(8'h38, 8'hFF, 4'h0, 2'h0);
        rd(8'h38, 8'h0A, 2'h0, "strobe off write");
        wr(8'h34, 8'h3F, 4'h1, 2'h0);
        rd(8'h34, 8'h00, 2'h0, "read-only bits");
        $display("test refused accesses done");
    endtask
    // ==========================================
    // run control
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        cyc(16);
        aresetn <= 1'h1;
        t_led_pins();
        t_latched();
        t_soft_reset();
        t_refused();
        complete_run();
    end
    initial begin
        cyc(20000);
        num_errors++;
        complete_run();
    end
endmodule // csl_status_led_tb_top
